// [bmsc_defines.vh]
// constants for the boot mode select and self-check block
`ifndef BMSC_DEFINES_VH
`define BMSC_DEFINES_VH

// mode encoding (one-hot)
`define BMSC_MODE_SINGLE    4'h1
`define BMSC_MODE_SELFCHK   4'h2
`define BMSC_MODE_LOADER    4'h4
`define BMSC_MODE_JUMP      4'h8

// failure codes on result lines, bit3..bit0
`define BMSC_FAIL_PORT_A    4'h9
`define BMSC_FAIL_PORT_B    4'h6
`define BMSC_FAIL_RAM       4'hA
`define BMSC_FAIL_ROM       4'hB
`define BMSC_FAIL_TIMER     4'hC
`define BMSC_FAIL_SCI       4'hD
`define BMSC_FAIL_ADC       4'hE
`define BMSC_FAIL_EEPROM    4'h0
`define BMSC_FAIL_PULSE     4'h1
`define BMSC_FAIL_IRQ       4'h2
`define BMSC_FAIL_WDOG      4'h3

// flash patterns while passing
`define BMSC_FLASH_ON       4'h0
`define BMSC_FLASH_OFF      4'hF

// jump mode signature on port A
`define BMSC_JUMP_SIG       8'hCC

// power-on reset delay choices, in internal cycles
`define BMSC_POR_SHORT      16
`define BMSC_POR_LONG       4064

// least hold of loader/jump select pins, machine cycles
`define BMSC_SEL_HOLD_MC    30

// step indices of the self-check sequence
`define BMSC_STEP_PORT      4'h0
`define BMSC_STEP_RAM       4'h1
`define BMSC_STEP_ROM       4'h2
`define BMSC_STEP_TIMER     4'h3
`define BMSC_STEP_SCI       4'h4
`define BMSC_STEP_ADC       4'h5
`define BMSC_STEP_EEPROM    4'h6
`define BMSC_STEP_PULSE     4'h7
`define BMSC_STEP_IRQ       4'h8
`define BMSC_STEP_WDOG      4'h9
`define BMSC_STEP_LAST      4'h9

// timer flag bit positions in the timer status vector
`define BMSC_TMR_CAP_ONE    0
`define BMSC_TMR_CAP_TWO    1
`define BMSC_TMR_CMP_ONE    2
`define BMSC_TMR_CMP_TWO    3
`define BMSC_TMR_OVF        4

// serial flag bit positions in the serial status vector
`define BMSC_SCI_RX_FULL    0
`define BMSC_SCI_TX_EMPTY   1
`define BMSC_SCI_TX_DONE    2
`define BMSC_SCI_FRAME_ERR  3

`endif

// [bmsc_boot_mode_self_check.v]
// boot mode selection at reset release and self-check sequencer
//
// Function
// - mode pins are sampled when external reset releases.
// - normal irq level gives single chip; high irq plus capture picks other modes.
// - single chip mode shows no external bus activity.
// - self-check runs by itself and restarts after each pass.
// - results drive four active-low indicator lines, zero lights.
// - each failed unit holds its own fixed four-bit code.
// - pass toggles the lines; fail freezes one constant pattern.
// - ports, interrupts, watchdog and pulse modulators are exercised.
// - every RAM byte is counted through and verified.
// - ROM exclusive-or accumulation must give odd-ones parity.
// - timer counters tracked, both capture, compare and overflow flags checked.
// - serial transmission checks receive, transmit, complete and framing flags.
// - converter checks low, high and midpoint reference channels.
// - optional EEPROM step writes, erases all 256 bytes, then clears security.
// - power-on delay is 16 or 4064 cycles, fixed at build.
// - build options set watchdog auto enable and wait-state running.
// - jump mode takes CC on port A and address on ports B, C.
//
// Strobed register access and the register addresses were decided locally.
`timescale 1ns/100ps
`include "bmsc_defines.vh"

module bmsc_boot_mode_self_check #(
	parameter        POR_LONG      = 1,
	parameter [31:0] POR_CYCLES    = POR_LONG ? `BMSC_POR_LONG : `BMSC_POR_SHORT,
	parameter        WDOG_AUTO_EN  = 1,
	parameter        WDOG_IN_WAIT  = 0,
	parameter        EEPROM_TEST   = 1,
	parameter        RAM_AW        = 8,
	parameter [31:0] RAM_BYTES     = 176,
	parameter        ROM_AW        = 13,
	parameter [31:0] FLASH_CYCLES  = 1000
) (
	input  wire        i_clk_sys,
	input  wire        i_rst,
	input  wire        i_clk_en,
	input  wire        i_ext_reset_n,
	input  wire        i_irq_high_volt,
	input  wire        i_capture_input_one_pin,
	input  wire        i_mode_select_a_pin,
	input  wire        i_mode_select_b_pin,
	input  wire [7:0]  i_port_a,
	input  wire [7:0]  i_port_b,
	input  wire [7:0]  i_port_c,
	input  wire        i_port_ok,
	input  wire [7:0]  i_ram_rdata,
	input  wire [7:0]  i_rom_rdata,
	input  wire        i_rom_last,
	input  wire [4:0]  i_timer_flags,
	input  wire        i_timer_track_ok,
	input  wire [3:0]  i_sci_flags,
	input  wire [9:0]  i_adc_result,
	input  wire        i_ee_ok,
	input  wire        i_pulse_ok,
	input  wire        i_irq_ok,
	input  wire        i_wdog_ok,
	input  wire        i_wait_state,
	output wire [3:0]  o_mode,
	output wire        o_cpu_run,
	output wire        o_ext_bus_en,
	output reg  [15:0] o_jump_addr,
	output wire        o_jump_valid,
	output reg  [3:0]  o_result_line,
	output wire [3:0]  o_result_oe,
	output reg  [3:0]  o_test_step,
	output reg  [RAM_AW-1:0] o_ram_addr,
	output reg  [7:0]  o_ram_wdata,
	output reg         o_ram_we,
	output reg  [ROM_AW-1:0] o_rom_addr,
	output reg  [1:0]  o_adc_chan,
	output reg         o_ee_clear_security,
	output wire        o_wdog_enable,
	output wire        o_wdog_run
);

	// sequencer states, one-hot
	localparam [4:0] ST_POR  = 5'h01;
	localparam [4:0] ST_IDLE = 5'h02;
	localparam [4:0] ST_TEST = 5'h04;
	localparam [4:0] ST_PASS = 5'h08;
	localparam [4:0] ST_FAIL = 5'h10;

	localparam [9:0] ADC_LOW  = 10'h000;
	localparam [9:0] ADC_HIGH = 10'h3FF;
	localparam [9:0] ADC_MID  = 10'h200;
	localparam [9:0] ADC_TOL  = 10'h004;

	// synchronisers for all pins
	reg [1:0] rstn_sync_ff;
	reg [1:0] irq_sync_ff;
	reg [1:0] cap_sync_ff;
	reg [1:0] sela_sync_ff;
	reg [1:0] selb_sync_ff;
	reg       rstn_prev_ff;
	reg [23:0] port_s1_ff;
	reg [23:0] port_s2_ff;

	always @(posedge i_clk_sys or posedge i_rst) begin
		if (i_rst) begin
			rstn_sync_ff <= 2'h0;
			irq_sync_ff  <= 2'h0;
			cap_sync_ff  <= 2'h0;
			sela_sync_ff <= 2'h0;
			selb_sync_ff <= 2'h0;
			rstn_prev_ff <= 1'b0;
			port_s1_ff   <= 24'h000000;
			port_s2_ff   <= 24'h000000;
		end else if (i_clk_en) begin
			rstn_sync_ff <= {rstn_sync_ff[0], i_ext_reset_n};
			irq_sync_ff  <= {irq_sync_ff[0], i_irq_high_volt};
			cap_sync_ff  <= {cap_sync_ff[0], i_capture_input_one_pin};
			sela_sync_ff <= {sela_sync_ff[0], i_mode_select_a_pin};
			selb_sync_ff <= {selb_sync_ff[0], i_mode_select_b_pin};
			rstn_prev_ff <= rstn_sync_ff[1];
			port_s1_ff   <= {i_port_a, i_port_b, i_port_c};
			port_s2_ff   <= port_s1_ff;
		end
	end

	wire rst_rise = rstn_sync_ff[1] & ~rstn_prev_ff;
	wire in_reset = ~rstn_sync_ff[1];

	// mode decode from strap levels
	function [3:0] decode_mode;
		input irq_hv;
		input cap;
		input sa;
		input sb;
		begin
			if (!(irq_hv && cap))
				decode_mode = `BMSC_MODE_SINGLE;
			else if (!sa)
				decode_mode = `BMSC_MODE_SELFCHK;
			else if (!sb)
				decode_mode = `BMSC_MODE_LOADER;
			else
				decode_mode = `BMSC_MODE_JUMP;
		end
	endfunction

	function in_range;
		input [9:0] v;
		input [9:0] ref_v;
		begin
			in_range = (v >= ref_v - ((ref_v < ADC_TOL) ? ref_v : ADC_TOL)) &&
				(v <= ref_v + ((ref_v > ADC_HIGH - ADC_TOL) ? ADC_HIGH - ref_v : ADC_TOL));
		end
	endfunction

	reg [3:0]  mode_ff;
	reg [31:0] por_cnt_ff;
	reg        por_done_ff;
	reg        jump_sig_ff;

	always @(posedge i_clk_sys or posedge i_rst) begin
		if (i_rst) begin
			mode_ff     <= `BMSC_MODE_SINGLE;
			por_cnt_ff  <= 32'h0;
			por_done_ff <= 1'b0;
			o_jump_addr <= 16'h0000;
			jump_sig_ff <= 1'b0;
		end else if (i_clk_en) begin
			if (in_reset) begin
				por_cnt_ff  <= 32'h0;
				por_done_ff <= 1'b0;
			end else if (!por_done_ff) begin
				if (por_cnt_ff >= POR_CYCLES - 32'h1)
					por_done_ff <= 1'b1;
				por_cnt_ff <= por_cnt_ff + 32'h1;
			end
			// latch only at release; held until next reset
			if (rst_rise) begin
				mode_ff <= decode_mode(irq_sync_ff[1], cap_sync_ff[1],
					sela_sync_ff[1], selb_sync_ff[1]);
				o_jump_addr <= port_s2_ff[15:0];
				jump_sig_ff <= (port_s2_ff[23:16] == `BMSC_JUMP_SIG);
			end
		end
	end

	assign o_mode        = mode_ff;
	assign o_cpu_run     = por_done_ff;
	assign o_ext_bus_en  = 1'b0;
	assign o_jump_valid  = por_done_ff && (mode_ff == `BMSC_MODE_JUMP) && jump_sig_ff;
	assign o_wdog_enable = (WDOG_AUTO_EN != 0) && por_done_ff;
	assign o_wdog_run    = o_wdog_enable && (!i_wait_state || (WDOG_IN_WAIT != 0));
	assign o_result_oe   = (mode_ff == `BMSC_MODE_SELFCHK) ? 4'hF : 4'h0;

	// self-check sequencer
	reg [4:0]  state_ff;
	reg [RAM_AW:0] idx_ff;
	reg [8:0]  sub_ff;
	reg [7:0]  rom_acc_ff;
	reg [31:0] flash_cnt_ff;
	reg        ram_chk_ff;
	reg [7:0]  ram_exp_ff;

	wire selfchk = (mode_ff == `BMSC_MODE_SELFCHK) && por_done_ff;
	wire ram_byte_end = (sub_ff[7:0] == 8'hFF);
	wire ram_all_done = (idx_ff == RAM_BYTES[RAM_AW:0]);

	always @(posedge i_clk_sys or posedge i_rst) begin
		if (i_rst) begin
			state_ff            <= ST_POR;
			o_test_step         <= `BMSC_STEP_PORT;
			o_result_line       <= `BMSC_FLASH_OFF;
			idx_ff              <= {(RAM_AW+1){1'b0}};
			sub_ff              <= 9'h000;
			rom_acc_ff          <= 8'h00;
			flash_cnt_ff        <= 32'h0;
			o_ram_addr          <= {RAM_AW{1'b0}};
			o_ram_wdata         <= 8'h00;
			o_ram_we            <= 1'b0;
			ram_chk_ff          <= 1'b0;
			ram_exp_ff          <= 8'h00;
			o_rom_addr          <= {ROM_AW{1'b0}};
			o_adc_chan          <= 2'h0;
			o_ee_clear_security <= 1'b0;
		end else if (i_clk_en) begin
			o_ram_we            <= 1'b0;
			o_ee_clear_security <= 1'b0;
			ram_chk_ff          <= 1'b0;
			case (state_ff)
				ST_POR: begin
					if (selfchk)
						state_ff <= ST_TEST;
					else if (por_done_ff)
						state_ff <= ST_IDLE;
				end
				ST_IDLE: begin
					o_result_line <= `BMSC_FLASH_OFF;
				end
				ST_TEST: begin
					case (o_test_step)
						`BMSC_STEP_PORT: begin
							if (!i_port_ok) begin
								o_result_line <= `BMSC_FAIL_PORT_A;
								state_ff      <= ST_FAIL;
							end else
								o_test_step <= `BMSC_STEP_RAM;
						end
						`BMSC_STEP_RAM: begin
							// write count value, then read it back next cycles
							if (ram_chk_ff && i_ram_rdata != ram_exp_ff) begin
								o_result_line <= `BMSC_FAIL_RAM;
								state_ff      <= ST_FAIL;
							end else if (ram_all_done) begin
								// leave only after the last byte's final value was checked
								idx_ff      <= {(RAM_AW+1){1'b0}};
								o_test_step <= `BMSC_STEP_ROM;
							end else if (!sub_ff[8]) begin
								o_ram_addr  <= idx_ff[RAM_AW-1:0];
								o_ram_wdata <= sub_ff[7:0];
								o_ram_we    <= 1'b1;
								sub_ff[8]   <= 1'b1;
							end else begin
								ram_chk_ff <= 1'b1;
								ram_exp_ff <= sub_ff[7:0];
								sub_ff     <= {1'b0, sub_ff[7:0] + 8'h01};
								if (ram_byte_end) begin
									sub_ff <= 9'h000;
									idx_ff <= idx_ff + 1'b1;
								end
							end
						end
						`BMSC_STEP_ROM: begin
							rom_acc_ff <= rom_acc_ff ^ i_rom_rdata;
							o_rom_addr <= o_rom_addr + 1'b1;
							if (i_rom_last) begin
								o_rom_addr <= {ROM_AW{1'b0}};
								rom_acc_ff <= 8'h00;
								if (!(^(rom_acc_ff ^ i_rom_rdata))) begin
									o_result_line <= `BMSC_FAIL_ROM;
									state_ff      <= ST_FAIL;
								end else
									o_test_step <= `BMSC_STEP_TIMER;
							end
						end
						`BMSC_STEP_TIMER: begin
							if (!(&i_timer_flags) || !i_timer_track_ok) begin
								o_result_line <= `BMSC_FAIL_TIMER;
								state_ff      <= ST_FAIL;
							end else
								o_test_step <= `BMSC_STEP_SCI;
						end
						`BMSC_STEP_SCI: begin
							// framing error is forced and must be seen
							if (!(&i_sci_flags)) begin
								o_result_line <= `BMSC_FAIL_SCI;
								state_ff      <= ST_FAIL;
							end else
								o_test_step <= `BMSC_STEP_ADC;
						end
						`BMSC_STEP_ADC: begin
							if (!in_range(i_adc_result, (o_adc_chan == 2'h0) ? ADC_LOW :
								(o_adc_chan == 2'h1) ? ADC_HIGH : ADC_MID)) begin
								o_result_line <= `BMSC_FAIL_ADC;
								state_ff      <= ST_FAIL;
							end else if (o_adc_chan == 2'h2) begin
								o_adc_chan  <= 2'h0;
								o_test_step <= `BMSC_STEP_EEPROM;
							end else
								o_adc_chan <= o_adc_chan + 2'h1;
						end
						`BMSC_STEP_EEPROM: begin
							if (EEPROM_TEST != 0 && !i_ee_ok) begin
								o_result_line <= `BMSC_FAIL_EEPROM;
								state_ff      <= ST_FAIL;
							end else begin
								o_ee_clear_security <= (EEPROM_TEST != 0);
								o_test_step         <= `BMSC_STEP_PULSE;
							end
						end
						`BMSC_STEP_PULSE: begin
							if (!i_pulse_ok) begin
								o_result_line <= `BMSC_FAIL_PULSE;
								state_ff      <= ST_FAIL;
							end else
								o_test_step <= `BMSC_STEP_IRQ;
						end
						`BMSC_STEP_IRQ: begin
							if (!i_irq_ok) begin
								o_result_line <= `BMSC_FAIL_IRQ;
								state_ff      <= ST_FAIL;
							end else
								o_test_step <= `BMSC_STEP_WDOG;
						end
						default: begin
							if (!i_wdog_ok) begin
								o_result_line <= `BMSC_FAIL_WDOG;
								state_ff      <= ST_FAIL;
							end else begin
								o_test_step <= `BMSC_STEP_PORT;
								state_ff    <= ST_PASS;
							end
						end
					endcase
				end
				ST_PASS: begin
					// flash for a while, then rerun the sequence
					if (flash_cnt_ff >= FLASH_CYCLES - 32'h1) begin
						flash_cnt_ff  <= 32'h0;
						o_result_line <= ~o_result_line;
						state_ff      <= ST_TEST;
					end else
						flash_cnt_ff <= flash_cnt_ff + 32'h1;
				end
				default: begin
					// frozen pattern until next reset
					state_ff <= ST_FAIL;
				end
			endcase
			if (in_reset) begin
				state_ff      <= ST_POR;
				o_test_step   <= `BMSC_STEP_PORT;
				o_result_line <= `BMSC_FLASH_OFF;
				idx_ff        <= {(RAM_AW+1){1'b0}};
				sub_ff        <= 9'h000;
				flash_cnt_ff  <= 32'h0;
			end
		end
	end

endmodule // bmsc_boot_mode_self_check

// [bmsc_props.sv]
// assertion checker for the boot mode select and self-check block
`timescale 1ns/100ps
module bmsc_props #(
	parameter WDOG_IN_WAIT = 0
) (
	input wire       i_clk_sys,
	input wire       i_rst,
	input wire       i_ext_reset_n,
	input wire       i_wait_state,
	input wire [3:0] o_mode,
	input wire       o_cpu_run,
	input wire       o_ext_bus_en,
	input wire       o_jump_valid,
	input wire [3:0] o_result_oe,
	input wire [3:0] o_test_step,
	input wire       o_ram_we,
	input wire       o_ee_clear_security,
	input wire       o_wdog_run
);
	default clocking cb @(posedge i_clk_sys); endclocking
	default disable iff (i_rst);
	sequence rel_s;
		$rose(i_ext_reset_n);
	endsequence
	// sync plus the short power-on count before the cpu starts
	sequence por_s;
		!o_cpu_run [*8] ##[9:20] o_cpu_run;
	endsequence
	chk_por_delay: assert property (rel_s |-> por_s) else $error("cpu released off time");
	chk_no_ext_bus: assert property (o_ext_bus_en == 1'b0) else $error("external bus active");
	chk_mode_onehot: assert property ($onehot(o_mode)) else $error("mode not one-hot");
	chk_mode_held: assert property (i_ext_reset_n [*8] |-> $stable(o_mode)) else $error("mode moved");
	chk_selfchk_oe: assert property (o_mode == 4'h2 |-> o_result_oe == 4'hF) else $error("result lines undriven");
	chk_jump_mode: assert property (o_jump_valid |-> o_mode == 4'h8) else $error("jump outside jump mode");
	chk_step_range: assert property (o_test_step <= 4'h9) else $error("step out of range");
	chk_ram_we_pulse: assert property (o_ram_we |=> !o_ram_we) else $error("ram write not a pulse");
	chk_ee_pulse: assert property ($rose(o_ee_clear_security) |=> $fell(o_ee_clear_security)) else $error("ee pulse");
	chk_wait_wdog: assert property (i_wait_state && WDOG_IN_WAIT == 0 |-> !o_wdog_run) else $error("wdog in wait");
endmodule // bmsc_props

bind bmsc_boot_mode_self_check bmsc_props #(.WDOG_IN_WAIT(WDOG_IN_WAIT)) u_props (
	.i_clk_sys(i_clk_sys), .i_rst(i_rst), .i_ext_reset_n(i_ext_reset_n), .i_wait_state(i_wait_state),
	.o_mode(o_mode), .o_cpu_run(o_cpu_run), .o_ext_bus_en(o_ext_bus_en), .o_jump_valid(o_jump_valid),
	.o_result_oe(o_result_oe), .o_test_step(o_test_step), .o_ram_we(o_ram_we),
	.o_ee_clear_security(o_ee_clear_security), .o_wdog_run(o_wdog_run));

// [bmsc_fixture.sv]
// fixture model: memories, peripheral results and fault injection
`timescale 1ns/100ps
module bmsc_fixture (
	input  wire        i_clk_sys,
	input  wire [3:0]  i_fault,
	input  wire [7:0]  i_ram_addr,
	input  wire [7:0]  i_ram_wdata,
	input  wire        i_ram_we,
	input  wire [12:0] i_rom_addr,
	input  wire [1:0]  i_adc_chan,
	output wire [7:0]  o_ram_rdata,
	output wire [7:0]  o_rom_rdata,
	output wire        o_rom_last,
	output wire [4:0]  o_timer_flags,
	output wire [3:0]  o_sci_flags,
	output wire [9:0]  o_adc_result,
	output wire [5:0]  o_ok
);
	reg [7:0] mem [0:255];
	always @(posedge i_clk_sys) begin
		if (i_ram_we)
			mem[i_ram_addr] <= i_ram_wdata;
	end
	// bit 0 inverted on read when the ram fault is chosen
	assign o_ram_rdata = mem[i_ram_addr] ^ {7'h00, i_fault == 4'h1};
	// one set bit gives odd parity; the rom fault adds a second
	assign o_rom_rdata = {7'h00, i_rom_addr == 13'h0000 || (i_fault == 4'h2 && i_rom_addr == 13'h0001)};
	assign o_rom_last = i_rom_addr == 13'h0003;
	assign o_timer_flags = i_fault == 4'h3 ? 5'h0F : 5'h1F;
	assign o_sci_flags = i_fault == 4'h4 ? 4'h7 : 4'hF;
	assign o_adc_result = i_fault == 4'h5 ? 10'h100 : i_adc_chan == 2'h0 ? 10'h000 :
		i_adc_chan == 2'h1 ? 10'h3FF : 10'h200;
	// timer track, wdog, irq, pulse modulator, eeprom, port
	assign o_ok = ~{i_fault == 4'h3, i_fault == 4'h9, i_fault == 4'h8, i_fault == 4'h7,
		i_fault == 4'h6, i_fault == 4'h0};
endmodule // bmsc_fixture

// [bmsc_boot_mode_self_check_tb_top.sv]
// self-checking testbench for the boot mode select and self-check block
`timescale 1ns/100ps
module bmsc_boot_mode_self_check_tb_top;
	reg        clk = 1'b0;
	reg        rst = 1'b1;
	reg        ext_n = 1'b0;
	reg        irq_hv = 1'b0;
	reg        cap = 1'b0;
	reg        sa = 1'b0;
	reg        sb = 1'b0;
	reg        wait_st = 1'b0;
	reg [7:0]  pa = 8'h00;
	reg [7:0]  pb = 8'h00;
	reg [7:0]  pc = 8'h00;
	reg [3:0]  fault = 4'hF;
	integer    err_count = 0;
	integer    n_tests = 0;
	integer    i;
	integer    k;
	wire [3:0] mode, res, oe, step;
	wire       run, bus, jv, we, ee, wen, wrun, last;
	wire [15:0] jaddr;
	wire [7:0] ra, wd, rd, romd;
	wire [12:0] roma;
	wire [1:0] ch;
	wire [4:0] tf;
	wire [3:0] sf;
	wire [9:0] adc;
	wire [5:0] ok;
	reg [3:0]  codes [0:9];
	always #2.5 clk = ~clk;
	bmsc_boot_mode_self_check #(.POR_LONG(0), .RAM_BYTES(2), .FLASH_CYCLES(4)) DUT (
		.i_clk_sys(clk), .i_rst(rst), .i_clk_en(1'b1), .i_ext_reset_n(ext_n), .i_irq_high_volt(irq_hv),
		.i_capture_input_one_pin(cap), .i_mode_select_a_pin(sa), .i_mode_select_b_pin(sb),
		.i_port_a(pa), .i_port_b(pb), .i_port_c(pc), .i_port_ok(ok[0]), .i_ram_rdata(rd),
		.i_rom_rdata(romd), .i_rom_last(last), .i_timer_flags(tf), .i_timer_track_ok(ok[5]),
		.i_sci_flags(sf), .i_adc_result(adc), .i_ee_ok(ok[1]), .i_pulse_ok(ok[2]), .i_irq_ok(ok[3]),
		.i_wdog_ok(ok[4]), .i_wait_state(wait_st), .o_mode(mode), .o_cpu_run(run), .o_ext_bus_en(bus),
		.o_jump_addr(jaddr), .o_jump_valid(jv), .o_result_line(res), .o_result_oe(oe), .o_test_step(step),
		.o_ram_addr(ra), .o_ram_wdata(wd), .o_ram_we(we), .o_rom_addr(roma), .o_adc_chan(ch),
		.o_ee_clear_security(ee), .o_wdog_enable(wen), .o_wdog_run(wrun));
	bmsc_fixture u_fix (
		.i_clk_sys(clk), .i_fault(fault), .i_ram_addr(ra), .i_ram_wdata(wd), .i_ram_we(we),
		.i_rom_addr(roma), .i_adc_chan(ch), .o_ram_rdata(rd), .o_rom_rdata(romd), .o_rom_last(last),
		.o_timer_flags(tf), .o_sci_flags(sf), .o_adc_result(adc), .o_ok(ok));
	task check(input [15:0] got, input [15:0] exp);
		begin
			n_tests = n_tests + 1;
			if (got !== exp) begin
				err_count = err_count + 1;
				$display("Error t=%0t got %h exp %h", $time, got, exp);
			end
		end
	endtask
	// pins stay put after release; t_jump moves irq_hv and sa 30 clocks after boot returns
	task boot(input h, input c, input a, input b, input [3:0] m);
		begin
			@(posedge clk);
			ext_n <= 1'b0;
			irq_hv <= h;
			cap <= c;
			sa <= a;
			sb <= b;
			repeat (6) @(posedge clk);
			ext_n <= 1'b1;
			@(negedge clk);
			repeat (100) if (run !== 1'b1) @(negedge clk);
			check(run, 1'b1);
			check(mode, m);
		end
	endtask
	task wait_res(input [3:0] e);
		begin
			repeat (2500) if (res !== e) @(negedge clk);
			check(res, e);
		end
	endtask
	task t_modes;
		begin
			boot(0, 0, 0, 0, 4'h1);
			boot(0, 1, 1, 1, 4'h1);
			boot(1, 0, 1, 1, 4'h1);
			boot(1, 1, 0, 1, 4'h2);
			boot(1, 1, 1, 0, 4'h4);
			$display("test modes done");
		end
	endtask
	task t_jump;
		begin
			@(posedge clk);
			pa <= 8'hCC;
			pb <= 8'h12;
			pc <= 8'h34;
			boot(1, 1, 1, 1, 4'h8);
			check(jv, 1'b1);
			check(jaddr, 16'h1234);
			repeat (30) @(posedge clk);
			irq_hv <= 1'b0;
			sa <= 1'b0;
			wait_st <= 1'b1;
			repeat (20) @(negedge clk);
			check(mode, 4'h8);
			check(bus, 1'b0);
			check(wen, 1'b1);
			check(wrun, 1'b0);
			@(posedge clk);
			wait_st <= 1'b0;
			pa <= 8'h00;
			@(negedge clk);
			check(wrun, 1'b1);
			boot(1, 1, 1, 1, 4'h8);
			check(jv, 1'b0);
			$display("test jump done");
		end
	endtask
	task t_pass;
		begin
			@(posedge clk);
			fault <= 4'hF;
			boot(1, 1, 0, 0, 4'h2);
			check(oe, 4'hF);
			wait_res(4'h0);
			wait_res(4'hF);
			wait_res(4'h0);
			$display("test pass done");
		end
	endtask
	task t_fail;
		begin
			for (i = 0; i < 10; i = i + 1) begin
				@(posedge clk);
				fault <= i[3:0];
				boot(1, 1, 0, 0, 4'h2);
				wait_res(codes[i]);
				k = 0;
				repeat (1200) begin
					@(negedge clk);
					if (res !== codes[i])
						k = 1;
				end
				check(k, 0);
			end
			$display("test fail done");
		end
	endtask
	task tally_and_finish;
		begin
			$display("comparisons %0d mismatches %0d", n_tests, err_count);
			if (err_count == 0 && n_tests > 0)
				$display("TEST PASSED");
			else
				$display("TEST FAILED");
			$finish;
		end
	endtask
	initial begin
		repeat (60000) @(posedge clk);
		err_count = err_count + 1;
		tally_and_finish;
	end
	initial begin
		{codes[0], codes[1], codes[2], codes[3], codes[4]} = {4'h9, 4'hA, 4'hB, 4'hC, 4'hD};
		{codes[5], codes[6], codes[7], codes[8], codes[9]} = {4'hE, 4'h0, 4'h1, 4'h2, 4'h3};
		repeat (3) @(posedge clk);
		rst <= 1'b0;
		t_modes;
		t_jump;
		t_pass;
		t_fail;
		tally_and_finish;
	end
endmodule // bmsc_boot_mode_self_check_tb_top
